// ### reset_seq_pkg.sv
// Shared constants, register map and state encoding of the reset source sequencer
package reset_seq_pkg;

    // Start-up delay length in system clock cycles
    localparam int DELAY_CYCLES = 1024;
    localparam int DELAY_CNT_W  = 11;

    // Register byte addresses on the AXI4-Lite port
    localparam logic [7:0] ADDR_STATUS     = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL    = 8'h10;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status register field positions
    localparam int ST_TIMEOUT  = 0;
    localparam int ST_PWRDOWN  = 1;
    localparam int ST_HALTED   = 2;
    localparam int ST_DELAY    = 3;
    localparam int ST_CHIPRST  = 4;
    localparam int ST_POWERON  = 5;

    // Interrupt event bit positions
    localparam int EV_W          = 4;
    localparam int EV_EXT_RESET  = 0;
    localparam int EV_WDT_FULL   = 1;
    localparam int EV_WARM_RESET = 2;
    localparam int EV_WAKE_DONE  = 3;

    // Control register: bit 0 lets watchdog time-outs reset the chip
    localparam int         CTL_WDT_EN    = 0;
    localparam logic [0:0] CONTROL_RESET = 1'h1;

    // Values driven into peripherals on a full chip reset
    localparam logic [7:0]  PORT_INIT  = 8'hFF;
    localparam logic [7:0]  TIMER_INIT = 8'h08;
    localparam logic [7:0]  CONV_INIT  = 8'h40;
    localparam logic [11:0] PC_INIT    = 12'h000;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        S_RUN   = 3'b001,
        S_HALT  = 3'b010,
        S_DELAY = 3'b100
    } state_e;

endpackage : reset_seq_pkg

// ### startup_delay_timer.sv
// Start-up delay counter: counts a fixed number of cycles after each restart
`timescale 1ns/1ps
module startup_delay_timer #(
    parameter int CYCLES = 1024,
    parameter int W      = 11
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic restart,
    input  wire logic enable,
    output wire logic done
);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] count;

    // Done on the last counted cycle, never in the restart cycle itself
    assign done = enable && !restart && (count == LAST);

    // Counter clears on restart and advances while the delay is active
    always_ff @(posedge clk) begin
        if (!rstn || restart) begin
            count <= '0;
        end else if (enable && !done) begin
            count <= count + W'(1);
        end
    end

endmodule : startup_delay_timer

// ### reset_source_sequencer.sv
// Reset source sequencer: cause decode, start-up delay, cause flags and AXI4-Lite status port
// Behaviour
// R1 - Pin reset when running or halted, or running watchdog time-out, resets whole chip.
// R2 - Watchdog time-out while halted gives warm reset of PC and SP only.
// R3 - Cause flags: power-up 00, pin run unchanged, pin halt 01, wdt 1u, wdt halt 11.
// R4 - Insert 1024-cycle start-up delay after every reset and every wake from halt.
// R5 - Hold chip reset through the delay; resume from halt only after it.
// R6 - Chip reset zeroes PC, disables interrupts, stops timer, inputs ports, resets SP.
// R7 - Chip reset clears watchdog, which restarts counting right after.
// R8 - General registers unknown only after power-on, untouched by other resets.
// R9 - Full resets load ports all ones, timer control 08h, converter control 40h.
// R10 - Powerdown flag cleared by power-up or clear instruction, set by halt; halt clears timeout.
// R11 - Outside agent requests reset by driving pin low, also clearing watchdog.
// R12 - Synchronise external reset pin to system clock before use.
`timescale 1ns/1ps
module reset_source_sequencer (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        EXT_RESET_PIN_N,
    input  wire logic        WDT_TIMEOUT,
    input  wire logic        HALT_EXEC,
    input  wire logic        WDT_CLEAR_EXEC,
    input  wire logic        WAKE_EVENT,
    output logic             CHIP_RESET,
    output logic             WARM_RESET,
    output logic             POWERON_RESET,
    output logic             CPU_STALL,
    output logic             WDT_CLEAR,
    output logic             TIMEOUT_FLAG,
    output logic             POWERDOWN_FLAG,
    output logic [11:0]      PC_INIT_VALUE,
    output logic [7:0]       PORT_INIT_VALUE,
    output logic [7:0]       TIMER_CTRL_INIT,
    output logic [7:0]       CONV_CTRL_INIT,
    output logic             IRQ,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    reset_seq_pkg::state_e state;
    reset_seq_pkg::state_e next_state;
    logic                              ext_meta;
    logic                              ext_sync;
    logic                              ext_low_q;
    logic                              delay_full;
    logic                              next_full;
    logic                              next_timeout;
    logic                              next_pwrdown;
    logic                              wdt_enable;
    logic [reset_seq_pkg::EV_W-1:0]    irq_status;
    logic [reset_seq_pkg::EV_W-1:0]    irq_enable;
    logic [7:0]                        awaddr_q;
    logic [31:0]                       wdata_q;
    logic [3:0]                        wstrb_q;
    // R12 synchronise pin
    // Two flops before any logic reads the pin; idle level is high
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
        end else begin
            ext_meta <= EXT_RESET_PIN_N;
            ext_sync <= ext_meta;
        end
    end

    // Decoded events; the pin is a level and also an edge for the flags
    wire in_run     = (state == reset_seq_pkg::S_RUN);
    wire in_halt    = (state == reset_seq_pkg::S_HALT);
    wire in_delay   = (state == reset_seq_pkg::S_DELAY);
    wire ext_low    = !ext_sync;
    wire ext_fall   = ext_low && !ext_low_q;
    wire wdt_evt    = WDT_TIMEOUT && wdt_enable && !ext_low;
    wire wdt_run    = wdt_evt && in_run;
    wire wdt_halt   = wdt_evt && in_halt;
    wire wake_halt  = WAKE_EVENT && in_halt && !ext_low && !wdt_halt;
    wire halt_entry = HALT_EXEC && in_run && !ext_low && !wdt_run;
    wire clr_instr  = WDT_CLEAR_EXEC && in_run && !ext_low && !wdt_run;
    wire restart    = ext_low || wdt_run || wdt_halt || wake_halt;
    wire delay_done;

    // R4 start-up delay
    startup_delay_timer #(
        .CYCLES (reset_seq_pkg::DELAY_CYCLES),
        .W      (reset_seq_pkg::DELAY_CNT_W)
    ) u_startup_delay_timer (
        .clk     (CLK),
        .rstn    (RSTN),
        .restart (restart),
        .enable  (in_delay),
        .done    (delay_done)
    );

    // R1 full reset sources
    // Pin held low keeps the delay restarting, so release starts the 1024 cycles
    always_comb begin
        next_state = state;
        next_full  = delay_full;
        if (ext_low) begin
            next_state = reset_seq_pkg::S_DELAY;
            next_full  = 1'b1;
        end else begin
            case (state)
                reset_seq_pkg::S_RUN: begin
                    if (wdt_run) begin
                        next_state = reset_seq_pkg::S_DELAY;
                        next_full  = 1'b1;
                    end else if (halt_entry) begin
                        next_state = reset_seq_pkg::S_HALT;
                    end
                end
                reset_seq_pkg::S_HALT: begin
                    // R2 warm reset wake
                    if (wdt_halt || wake_halt) begin
                        next_state = reset_seq_pkg::S_DELAY;
                        next_full  = 1'b0;
                    end
                end
                reset_seq_pkg::S_DELAY: begin
                    // R5 resume after delay
                    if (delay_done) begin
                        next_state = reset_seq_pkg::S_RUN;
                        next_full  = 1'b0;
                    end
                end
                default: begin
                    next_state = reset_seq_pkg::S_DELAY;
                    next_full  = 1'b1;
                end
            endcase
        end
    end

    // R3 cause flags
    // Pin reset during normal running leaves both flags as they were
    always_comb begin
        next_timeout = TIMEOUT_FLAG;
        next_pwrdown = POWERDOWN_FLAG;
        if (ext_fall) begin
            if (in_halt) begin
                next_timeout = 1'b0;
                next_pwrdown = 1'b1;
            end
        end else if (wdt_run) begin
            next_timeout = 1'b1;
        end else if (wdt_halt) begin
            next_timeout = 1'b1;
            next_pwrdown = 1'b1;
        end else if (halt_entry) begin
            // R10 halt sets powerdown
            next_timeout = 1'b0;
            next_pwrdown = 1'b1;
        end else if (clr_instr) begin
            // R10 clear instruction
            next_pwrdown = 1'b0;
        end
    end

    // Sequencer state; power-up starts in a full-reset delay with both flags clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state          <= reset_seq_pkg::S_DELAY;
            delay_full     <= 1'b1;
            ext_low_q      <= 1'b0;
            TIMEOUT_FLAG   <= 1'b0;
            POWERDOWN_FLAG <= 1'b0;
        end else begin
            state          <= next_state;
            delay_full     <= next_full;
            ext_low_q      <= ext_low;
            TIMEOUT_FLAG   <= next_timeout;
            POWERDOWN_FLAG <= next_pwrdown;
        end
    end

    // Next values of the reset outputs, so each output is a plain flop
    wire next_chip  = (next_state == reset_seq_pkg::S_DELAY) && next_full;
    wire next_stall = (next_state != reset_seq_pkg::S_RUN);
    wire next_wclr  = next_chip || ext_low || halt_entry;

    // R5 hold chip reset
    // R6 chip reset effects
    // R7 watchdog clear
    // Watchdog clear drops with chip reset so it restarts counting at once
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            CHIP_RESET <= 1'b1;
            CPU_STALL  <= 1'b1;
            WDT_CLEAR  <= 1'b1;
            WARM_RESET <= 1'b0;
        end else begin
            CHIP_RESET <= next_chip;
            CPU_STALL  <= next_stall;
            WDT_CLEAR  <= next_wclr;
            WARM_RESET <= wdt_halt;
        end
    end

    // R8 power-on only
    // Marks general registers unknown; cleared at the end of the power-up delay
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            POWERON_RESET <= 1'b1;
        end else if (in_delay && delay_done) begin
            POWERON_RESET <= 1'b0;
        end
    end

    // R9 initial values
    // Peripherals load these while CHIP_RESET is high; warm reset never asserts it
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            PC_INIT_VALUE   <= reset_seq_pkg::PC_INIT;
            PORT_INIT_VALUE <= reset_seq_pkg::PORT_INIT;
            TIMER_CTRL_INIT <= reset_seq_pkg::TIMER_INIT;
            CONV_CTRL_INIT  <= reset_seq_pkg::CONV_INIT;
        end
    end

    // Interrupt events; the sticky set wins over a same-cycle clear
    wire [reset_seq_pkg::EV_W-1:0] events = {in_delay && delay_done && !delay_full, wdt_halt, wdt_run, ext_fall};

    // Write decode on the held address and data
    wire do_write  = !AWREADY && !WREADY && !BVALID;
    wire lane0     = wstrb_q[0];
    wire wr_enable = do_write && lane0 && (awaddr_q == reset_seq_pkg::ADDR_IRQ_ENABLE);
    wire wr_clear  = do_write && lane0 && (awaddr_q == reset_seq_pkg::ADDR_IRQ_CLEAR);
    wire wr_ctrl   = do_write && lane0 && (awaddr_q == reset_seq_pkg::ADDR_CONTROL);
    wire wr_mapped = (awaddr_q == reset_seq_pkg::ADDR_STATUS) || (awaddr_q == reset_seq_pkg::ADDR_IRQ_STATUS)
                  || (awaddr_q == reset_seq_pkg::ADDR_IRQ_ENABLE) || (awaddr_q == reset_seq_pkg::ADDR_IRQ_CLEAR)
                  || (awaddr_q == reset_seq_pkg::ADDR_CONTROL);
    wire [reset_seq_pkg::EV_W-1:0] clr_bits = wr_clear ? wdata_q[reset_seq_pkg::EV_W-1:0] : '0;
    wire [reset_seq_pkg::EV_W-1:0] next_irq_status = (irq_status & ~clr_bits) | events;

    // Sticky status, enable, control and the level interrupt
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            irq_status <= '0;
            irq_enable <= '0;
            wdt_enable <= reset_seq_pkg::CONTROL_RESET[0];
            IRQ        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_enable) begin
                irq_enable <= wdata_q[reset_seq_pkg::EV_W-1:0];
            end
            if (wr_ctrl) begin
                wdt_enable <= wdata_q[reset_seq_pkg::CTL_WDT_EN];
            end
            IRQ <= |(next_irq_status & (wr_enable ? wdata_q[reset_seq_pkg::EV_W-1:0] : irq_enable));
        end
    end

    // Write channels: address and data taken in either order, answer after both
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            AWREADY  <= 1'b1;
            WREADY   <= 1'b1;
            BVALID   <= 1'b0;
            BRESP    <= reset_seq_pkg::RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY  <= 1'b0;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                WREADY  <= 1'b0;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (do_write) begin
                BVALID <= 1'b1;
                BRESP  <= wr_mapped ? reset_seq_pkg::RESP_OKAY : reset_seq_pkg::RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // Read decode straight from the offered address
    logic [31:0] status_word;
    always_comb begin
        status_word                             = 32'h0000_0000;
        status_word[reset_seq_pkg::ST_TIMEOUT]  = TIMEOUT_FLAG;
        status_word[reset_seq_pkg::ST_PWRDOWN]  = POWERDOWN_FLAG;
        status_word[reset_seq_pkg::ST_HALTED]   = in_halt;
        status_word[reset_seq_pkg::ST_DELAY]    = in_delay;
        status_word[reset_seq_pkg::ST_CHIPRST]  = CHIP_RESET;
        status_word[reset_seq_pkg::ST_POWERON]  = POWERON_RESET;
    end

    wire rd_status = (ARADDR == reset_seq_pkg::ADDR_STATUS);
    wire rd_irqsts = (ARADDR == reset_seq_pkg::ADDR_IRQ_STATUS);
    wire rd_irqen  = (ARADDR == reset_seq_pkg::ADDR_IRQ_ENABLE);
    wire rd_clear  = (ARADDR == reset_seq_pkg::ADDR_IRQ_CLEAR);
    wire rd_ctrl   = (ARADDR == reset_seq_pkg::ADDR_CONTROL);
    wire rd_mapped = rd_status || rd_irqsts || rd_irqen || rd_clear || rd_ctrl;
    wire [31:0] rd_word = rd_status ? status_word : rd_irqsts ? {28'h0000000, irq_status}
                        : rd_irqen  ? {28'h0000000, irq_enable} : rd_ctrl ? {31'h0, wdt_enable}
                        : 32'h0000_0000;   // Clear register and holes read zero

    // Read channel: one read outstanding, data captured at the address handshake
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= reset_seq_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_word;
            RRESP   <= rd_mapped ? reset_seq_pkg::RESP_OKAY : reset_seq_pkg::RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

endmodule : reset_source_sequencer

// ### pin_wdt_model.sv
// Behavioural model of the external reset pin driver and the watchdog overflow source
`timescale 1ns/1ps
module pin_wdt_model (
    input  wire logic clk,
    output logic      pin_n,
    output logic      wdt_pulse
);
    // Pin idles released, overflow idles low
    initial begin
        pin_n = 1'b1;
        wdt_pulse = 1'b0;
    end

    // pin held low
    // Low level for n edges requests a reset and clears the watchdog
    task automatic pin_low(input int n);
        pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        pin_n <= 1'b1;
    endtask : pin_low

    // One-cycle overflow pulse, the only form the watchdog produces
    task automatic overflow();
        wdt_pulse <= 1'b1;
        @(posedge clk);
        wdt_pulse <= 1'b0;
    endtask : overflow
endmodule : pin_wdt_model

// ### reset_seq_monitor.sv
// Concurrent checks on the reset source sequencer ports
`timescale 1ns/1ps
module reset_seq_monitor (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        EXT_RESET_PIN_N,
    input wire logic        WDT_TIMEOUT,
    input wire logic        HALT_EXEC,
    input wire logic        WDT_CLEAR_EXEC,
    input wire logic        CHIP_RESET,
    input wire logic        WARM_RESET,
    input wire logic        POWERON_RESET,
    input wire logic        CPU_STALL,
    input wire logic        WDT_CLEAR,
    input wire logic        TIMEOUT_FLAG,
    input wire logic        POWERDOWN_FLAG,
    input wire logic [11:0] PC_INIT_VALUE,
    input wire logic [7:0]  PORT_INIT_VALUE,
    input wire logic [7:0]  TIMER_CTRL_INIT,
    input wire logic [7:0]  CONV_CTRL_INIT,
    input wire logic        IRQ
);
    logic [11:0] chip_cnt;
    logic [11:0] stall_cnt;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Run lengths; reset time counts as full so only event-driven delays are measured
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            chip_cnt <= 12'hFFF;
            stall_cnt <= 12'hFFF;
        end else begin
            chip_cnt <= !CHIP_RESET ? 12'h000 : (chip_cnt == 12'hFFF ? chip_cnt : chip_cnt + 12'h001);
            stall_cnt <= !CPU_STALL ? 12'h000 : (stall_cnt == 12'hFFF ? stall_cnt : stall_cnt + 12'h001);
        end
    end

    property p_wdt_run;
        !CPU_STALL && WDT_TIMEOUT |=> CHIP_RESET;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("time-out while running gave no chip reset");
    property p_pin;
        (!EXT_RESET_PIN_N) [*4] |-> CHIP_RESET && WDT_CLEAR;
    endproperty
    a_pin: assert property (p_pin) else $error("low pin not followed by chip reset");
    property p_init;
        CHIP_RESET |-> PC_INIT_VALUE == reset_seq_pkg::PC_INIT && PORT_INIT_VALUE == reset_seq_pkg::PORT_INIT
            && TIMER_CTRL_INIT == reset_seq_pkg::TIMER_INIT && CONV_CTRL_INIT == reset_seq_pkg::CONV_INIT;
    endproperty
    a_init: assert property (p_init) else $error("wrong initial values during chip reset");
    property p_por;
        POWERON_RESET |-> CHIP_RESET;
    endproperty
    a_por: assert property (p_por) else $error("power-on mark outside chip reset");
    property p_warm;
        WARM_RESET |-> !CHIP_RESET ##1 !WARM_RESET;
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset not a lone pulse");
    property p_warm_flags;
        WARM_RESET |-> TIMEOUT_FLAG && POWERDOWN_FLAG;
    endproperty
    a_warm_flags: assert property (p_warm_flags) else $error("warm reset flags not 1,1");
    property p_halt;
        !CPU_STALL && HALT_EXEC && EXT_RESET_PIN_N && !WDT_TIMEOUT |=> POWERDOWN_FLAG && !TIMEOUT_FLAG && CPU_STALL;
    endproperty
    a_halt: assert property (p_halt) else $error("halt entry flags wrong");
    property p_clr;
        !CPU_STALL && WDT_CLEAR_EXEC && !HALT_EXEC && !WDT_TIMEOUT && EXT_RESET_PIN_N |=> !POWERDOWN_FLAG;
    endproperty
    a_clr: assert property (p_clr) else $error("clear instruction left powerdown set");
    property p_delay;
        $fell(CHIP_RESET) |-> chip_cnt >= reset_seq_pkg::DELAY_CYCLES;
    endproperty
    a_delay: assert property (p_delay) else $error("chip reset released before the delay");
    property p_stall;
        $fell(CPU_STALL) |-> stall_cnt >= reset_seq_pkg::DELAY_CYCLES;
    endproperty
    a_stall: assert property (p_stall) else $error("core resumed before the delay");

    cover property (WARM_RESET);
    cover property ($fell(CHIP_RESET));
    cover property (IRQ);
endmodule : reset_seq_monitor

bind reset_source_sequencer reset_seq_monitor mon (.CLK, .RSTN, .EXT_RESET_PIN_N, .WDT_TIMEOUT, .HALT_EXEC,
    .WDT_CLEAR_EXEC, .CHIP_RESET, .WARM_RESET, .POWERON_RESET, .CPU_STALL, .WDT_CLEAR, .TIMEOUT_FLAG,
    .POWERDOWN_FLAG, .PC_INIT_VALUE, .PORT_INIT_VALUE, .TIMER_CTRL_INIT, .CONV_CTRL_INIT, .IRQ);

// ### reset_source_sequencer_test.sv
// Self-checking testbench of the reset source sequencer
`timescale 1ns/1ps
module reset_source_sequencer_test;
    logic        CLK = 0, RSTN = 0, HALT_EXEC = 0, WDT_CLEAR_EXEC = 0, WAKE_EVENT = 0;
    logic        EXT_RESET_PIN_N, WDT_TIMEOUT, CHIP_RESET, WARM_RESET, POWERON_RESET, CPU_STALL;
    logic        WDT_CLEAR, TIMEOUT_FLAG, POWERDOWN_FLAG, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [11:0] PC_INIT_VALUE;
    logic [7:0]  PORT_INIT_VALUE, TIMER_CTRL_INIT, CONV_CTRL_INIT, AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, RDATA;
    logic [3:0]  WSTRB = 0;
    logic [1:0]  BRESP, RRESP;
    logic [33:0] expq[$];
    int          n_fail = 0, tests_run = 0, cyc = 0;

    reset_source_sequencer dut (.CLK, .RSTN, .EXT_RESET_PIN_N, .WDT_TIMEOUT, .HALT_EXEC, .WDT_CLEAR_EXEC,
        .WAKE_EVENT, .CHIP_RESET, .WARM_RESET, .POWERON_RESET, .CPU_STALL, .WDT_CLEAR, .TIMEOUT_FLAG,
        .POWERDOWN_FLAG, .PC_INIT_VALUE, .PORT_INIT_VALUE, .TIMER_CTRL_INIT, .CONV_CTRL_INIT, .IRQ,
        .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
        .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
    pin_wdt_model pm (.clk(CLK), .pin_n(EXT_RESET_PIN_N), .wdt_pulse(WDT_TIMEOUT));

    always #5 CLK = ~CLK;

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("Counts: %0d compared, %0d failed", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Hang guard: the run needs a little over six thousand cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 30000) begin
            n_fail++;
            print_verdict();
        end
    end

    // Each read answer is matched against the oldest noted expectation
    always @(posedge CLK) begin
        if (RVALID === 1'b1 && RREADY === 1'b1) begin
            if (expq.size() == 0) chk(1, 0, "unexpected read");
            else chk({RRESP, RDATA}, expq.pop_front(), "read answer");
        end
    end

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        BREADY <= 1'b1;
        fork
            begin AWVALID <= 1'b1; do @(posedge CLK); while (AWREADY !== 1'b1); AWVALID <= 1'b0; end
            begin WVALID <= 1'b1; do @(posedge CLK); while (WREADY !== 1'b1); WVALID <= 1'b0; end
        join
        do @(posedge CLK); while (BVALID !== 1'b1);
        chk(BRESP, r, "write response");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        expq.push_back({r, d});
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
    endtask : rd

    // Counts stalled cycles; sync and register stages add a few to the fixed delay
    task automatic wait_run(input logic full);
        int n;
        n = 0;
        // First edge always waited, so a stall launched at the caller's edge is counted
        do begin
            @(posedge CLK);
            n++;
            // chip reset only for full resets
            if (n == 4) chk(CHIP_RESET, full, "chip reset level");
        end while (CPU_STALL !== 1'b0 && n < 5000);
        chk(n >= reset_seq_pkg::DELAY_CYCLES && n <= reset_seq_pkg::DELAY_CYCLES + 6, 1, "delay length");
    endtask : wait_run

    task automatic halt();
        HALT_EXEC <= 1'b1;
        @(posedge CLK);
        HALT_EXEC <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask : halt

    // Main sequence; status reads carry the cause flags in bits 1:0
    initial begin
        void'($urandom(32'hEC58));
        repeat (6) @(posedge CLK);
        chk({PC_INIT_VALUE, PORT_INIT_VALUE, TIMER_CTRL_INIT, CONV_CTRL_INIT}, 36'h000FF0840, "init");
        RSTN <= 1'b1;
        wait_run(1'b1);
        rd(reset_seq_pkg::ADDR_STATUS, 32'h0);
        rd(reset_seq_pkg::ADDR_CONTROL, 32'h1);
        rd(reset_seq_pkg::ADDR_IRQ_ENABLE, 32'h0);
        rd(8'h20, 32'h0, reset_seq_pkg::RESP_SLVERR);
        wr(8'h20, 32'h0, 4'hF, reset_seq_pkg::RESP_SLVERR);
        wr(reset_seq_pkg::ADDR_CONTROL, 32'h0, 4'hE, reset_seq_pkg::RESP_OKAY);
        rd(reset_seq_pkg::ADDR_CONTROL, 32'h1);
        wr(reset_seq_pkg::ADDR_CONTROL, 32'h0, 4'hF, reset_seq_pkg::RESP_OKAY);
        rd(reset_seq_pkg::ADDR_CONTROL, 32'h0);
        wr(reset_seq_pkg::ADDR_CONTROL, 32'h1, 4'hF, reset_seq_pkg::RESP_OKAY);
        wr(reset_seq_pkg::ADDR_IRQ_ENABLE, 32'hF, 4'hF, reset_seq_pkg::RESP_OKAY);
        $display("test power-up and registers done");
        pm.overflow();
        wait_run(1'b1);
        rd(reset_seq_pkg::ADDR_STATUS, 32'h1);
        rd(reset_seq_pkg::ADDR_IRQ_STATUS, 32'h2);
        chk(IRQ, 1'b1, "irq raised");
        wr(reset_seq_pkg::ADDR_IRQ_ENABLE, 32'h0, 4'hF, reset_seq_pkg::RESP_OKAY);
        repeat (2) @(posedge CLK);
        chk(IRQ, 1'b0, "irq masked");
        wr(reset_seq_pkg::ADDR_IRQ_CLEAR, 32'hF, 4'hF, reset_seq_pkg::RESP_OKAY);
        rd(reset_seq_pkg::ADDR_IRQ_STATUS, 32'h0);
        $display("test watchdog in run done");
        halt();
        rd(reset_seq_pkg::ADDR_STATUS, 32'h6);
        pm.overflow();
        wait_run(1'b0);
        rd(reset_seq_pkg::ADDR_STATUS, 32'h3);
        $display("test warm reset done");
        halt();
        pm.pin_low(6 + $urandom_range(0, 20));
        wait_run(1'b1);
        rd(reset_seq_pkg::ADDR_STATUS, 32'h2);
        pm.pin_low(6 + $urandom_range(0, 20));
        wait_run(1'b1);
        rd(reset_seq_pkg::ADDR_STATUS, 32'h2);
        $display("test pin resets done");
        WDT_CLEAR_EXEC <= 1'b1;
        @(posedge CLK);
        WDT_CLEAR_EXEC <= 1'b0;
        rd(reset_seq_pkg::ADDR_STATUS, 32'h0);
        halt();
        WAKE_EVENT <= 1'b1;
        @(posedge CLK);
        WAKE_EVENT <= 1'b0;
        wait_run(1'b0);
        rd(reset_seq_pkg::ADDR_STATUS, 32'h2);
        $display("test clear and wake done");
        repeat (3) @(posedge CLK);
        chk(expq.size(), 0, "reads answered");
        print_verdict();
    end
endmodule : reset_source_sequencer_test
